/* File: tc16_timer.sv */
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "tc16_cfg.svh"
//
// Operation
// - Three-bit clock select picks the tick; zero stops counting.
// - Upper counter location reaches the shared latch, not the counter.
// - Lower read copies upper byte to latch; lower write loads from it.
// - Each tick clears, increments or decrements as the mode needs.
// - Counter readable and writable at any time, ticking or not.
// - Processor write beats clear or count in the same cycle.
// - Four-bit waveform mode: upper two in ctrl B, lower two in ctrl A.
// - Overflow flag set where the mode says; it can request an interrupt.
// - Qualifying edge copies counter to capture and sets flag same cycle.
// - Capture flag interrupts when enabled; cleared by service or write one.
// - Capture lower read first loads latch; upper read returns latch.
// - Capture writable only in capture-top modes; upper then lower.
// - Comparator capture select switches trigger to comparator output.
// - Only the first timer instance offers the comparator trigger.
// - Both trigger inputs sampled alike; filter adds four clocks delay.
// - Edge detector off only in capture-top modes; filter keeps running.
// - Pin driven by own port output captures like an external event.
// - Filter output changes only after four equal samples.
// - Filter enabled in ctrl B, runs on undivided clock.
// - Each new event overwrites the capture value.
module tc16_timer import tc16_pkg::*; #(
    parameter bit HAS_COMPARATOR = 1'b1
) (
    input wire logic clk, // 10 MHz clock
    input wire logic reset, // Async, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // Unmapped address
    input wire logic capture_pin, // Pin level incl. own port drive
    input wire logic comparator_output, // Comparator result
    input wire logic ext_clock_pin, // External tick pin
    input wire logic capture_irq_ack, // Capture interrupt serviced
    input wire logic overflow_irq_ack, // Overflow interrupt serviced
    output logic capture_irq, // Capture interrupt request
    output logic overflow_irq // Overflow interrupt request
);
    logic [7:0] ctrl_reg_a_r, ctrl_reg_b_r, irq_mask_reg_r, comp_ctrl_r;
    logic [7:0] temp_r;
    tc16_word_t timer_count_r, capture_value_r;
    logic overflow_flag_r, capture_flag_r, dir_down_r;
    logic [9:0] presc_r;
    logic ext_prev_r, cap_samp_r, nf_out_r, edge_prev_r;
    logic [`TC16_NF_LEN-2:0] nf_sh_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r, capture_irq_r, overflow_irq_r;

    function automatic tc16_word_t fixed_top(input logic [1:0] res);
        unique case (res)
            2'b01: fixed_top = `TC16_TOP8;
            2'b10: fixed_top = `TC16_TOP9;
            2'b11: fixed_top = `TC16_TOP10;
            2'b00: fixed_top = `TC16_MAX;
        endcase
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    // Bus decode; one wait state so read data comes from a flop
    wire acc_first = psel && penable && !pready_r;
    wire acc_done = psel && penable && pready_r;
    wire rd_take = acc_first && !pwrite;
    wire wr_do = acc_done && pwrite;
    wire [7:0] wb = pwdata[7:0];
    wire a_ca = hit(paddr, `TC16_ADR_CTRL_A);
    wire a_cb = hit(paddr, `TC16_ADR_CTRL_B);
    wire a_clo = hit(paddr, `TC16_ADR_CNT_LO);
    wire a_chi = hit(paddr, `TC16_ADR_CNT_HI);
    wire a_plo = hit(paddr, `TC16_ADR_CAP_LO);
    wire a_phi = hit(paddr, `TC16_ADR_CAP_HI);
    wire a_msk = hit(paddr, `TC16_ADR_MASK);
    wire a_flg = hit(paddr, `TC16_ADR_FLAG);
    wire a_cmp = hit(paddr, `TC16_ADR_COMP);
    wire mapped = a_ca | a_cb | a_clo | a_chi | a_plo | a_phi | a_msk | a_flg | a_cmp;

    // Mode decode
    wire [3:0] waveform_mode = {ctrl_reg_b_r[4:3], ctrl_reg_a_r[1:0]};
    wire cap_top = (waveform_mode == 4'd8) || (waveform_mode == 4'd10)
        || (waveform_mode == 4'd12) || (waveform_mode == 4'd14);
    wire updown = (waveform_mode == 4'd1) || (waveform_mode == 4'd2)
        || (waveform_mode == 4'd3) || (waveform_mode == 4'd8) || (waveform_mode == 4'd10);
    wire ctc = (waveform_mode == 4'd12);
    wire [1:0] res_sel = (waveform_mode[3:2] == 2'b01 || waveform_mode[3:2] == 2'b00)
        ? waveform_mode[1:0] : 2'b00;
    wire tc16_word_t top = cap_top ? capture_value_r : fixed_top(res_sel);

    // Tick source
    tc16_cs_e cs;
    assign cs = tc16_cs_e'(ctrl_reg_b_r[2:0]);
    logic tick;
    always_comb begin
        unique case (cs)
            TC16_CS_STOP: tick = 1'b0;
            TC16_CS_DIV1: tick = 1'b1;
            TC16_CS_DIV8: tick = &presc_r[2:0];
            TC16_CS_DIV64: tick = &presc_r[5:0];
            TC16_CS_DIV256: tick = &presc_r[7:0];
            TC16_CS_DIV1024: tick = &presc_r;
            TC16_CS_EXT_FALL: tick = ext_prev_r && !ext_clock_pin;
            TC16_CS_EXT_RISE: tick = !ext_prev_r && ext_clock_pin;
        endcase
    end

    // Counter next value
    wire at_top = (timer_count_r == top);
    wire at_bot = (timer_count_r == `TC16_RST_WORD);
    wire cnt_wr = wr_do && a_clo;
    tc16_word_t cnt_nxt;
    logic dir_nxt, ovf_evt;
    always_comb begin
        cnt_nxt = timer_count_r;
        dir_nxt = dir_down_r;
        ovf_evt = 1'b0;
        if (tick) begin
            if (updown) begin
                if (!dir_down_r && at_top) begin
                    dir_nxt = 1'b1;
                    cnt_nxt = timer_count_r - 16'h0001;
                end else if (dir_down_r && at_bot) begin
                    dir_nxt = 1'b0;
                    cnt_nxt = timer_count_r + 16'h0001;
                    ovf_evt = 1'b1;
                end else begin
                    cnt_nxt = dir_down_r ? timer_count_r - 16'h0001
                                         : timer_count_r + 16'h0001;
                end
            end else if (at_top) begin
                cnt_nxt = `TC16_RST_WORD;
                ovf_evt = !ctc || (timer_count_r == `TC16_MAX);
            end else begin
                cnt_nxt = timer_count_r + 16'h0001;
                ovf_evt = ctc && (timer_count_r == `TC16_MAX);
            end
        end
        if (cnt_wr) begin
            cnt_nxt = {temp_r, wb};
        end
    end

    // Capture path; comparator only on the first instance
    wire src_cmp = HAS_COMPARATOR && comp_ctrl_r[`TC16_B_COMPARATOR_CAPTURE_SELECT];
    wire cap_src = src_cmp ? comparator_output : capture_pin;
    wire nf_en = ctrl_reg_b_r[`TC16_B_NF];
    // Newest sample is the fourth vote, so the filter adds exactly four clocks
    wire [`TC16_NF_LEN-1:0] nf_win = {nf_sh_r, cap_samp_r};
    wire nf_agree = (&nf_win) || !(|nf_win);
    wire nf_nxt = nf_agree ? cap_samp_r : nf_out_r;
    wire det_in = nf_en ? nf_out_r : cap_samp_r;
    wire rise_sel = ctrl_reg_b_r[`TC16_B_EDGE];
    wire cap_evt = !cap_top && (det_in != edge_prev_r)
        && (det_in == rise_sel);
    wire cap_wr = wr_do && a_plo && cap_top;

    // Temp latch shared by every 16-bit register
    logic [7:0] temp_nxt;
    always_comb begin
        temp_nxt = temp_r;
        if (rd_take && a_clo) temp_nxt = timer_count_r[15:8];
        if (rd_take && a_plo) temp_nxt = capture_value_r[15:8];
        if (wr_do && (a_chi || a_phi)) temp_nxt = wb;
    end

    // Read mux
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = `TC16_RST_BYTE;
        if (a_ca) rd_byte = ctrl_reg_a_r;
        if (a_cb) rd_byte = ctrl_reg_b_r;
        if (a_clo) rd_byte = timer_count_r[7:0];
        if (a_chi || a_phi) rd_byte = temp_r;
        if (a_plo) rd_byte = capture_value_r[7:0];
        if (a_msk) rd_byte = irq_mask_reg_r;
        if (a_flg) rd_byte = {2'b00, capture_flag_r, 4'h0, overflow_flag_r};
        if (a_cmp) rd_byte = comp_ctrl_r;
    end

    // Set wins over clear on both flags
    wire flg_wr = wr_do && a_flg;
    wire cap_clr = (flg_wr && wb[`TC16_F_CAP]) || capture_irq_ack;
    wire ovf_clr = (flg_wr && wb[`TC16_F_OVF]) || overflow_irq_ack;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_reg_a_r <= `TC16_RST_BYTE;
            ctrl_reg_b_r <= `TC16_RST_BYTE;
            irq_mask_reg_r <= `TC16_RST_BYTE;
            comp_ctrl_r <= `TC16_RST_BYTE;
        end else if (wr_do) begin
            if (a_ca) ctrl_reg_a_r <= wb;
            if (a_cb) ctrl_reg_b_r <= wb;
            if (a_msk) irq_mask_reg_r <= wb;
            if (a_cmp) comp_ctrl_r <= wb;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            timer_count_r <= `TC16_RST_WORD;
            dir_down_r <= 1'b0;
            presc_r <= 10'h000;
            ext_prev_r <= 1'b0;
            temp_r <= `TC16_RST_BYTE;
        end else begin
            timer_count_r <= cnt_nxt;
            dir_down_r <= dir_nxt;
            presc_r <= presc_r + 10'h001;
            ext_prev_r <= ext_clock_pin;
            temp_r <= temp_nxt;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            capture_value_r <= `TC16_RST_WORD;
            capture_flag_r <= 1'b0;
            overflow_flag_r <= 1'b0;
        end else begin
            if (cap_evt) capture_value_r <= timer_count_r;
            else if (cap_wr) capture_value_r <= {temp_r, wb};
            capture_flag_r <= cap_evt || (capture_flag_r && !cap_clr);
            overflow_flag_r <= ovf_evt || (overflow_flag_r && !ovf_clr);
        end
    end

    // Filter runs on the raw clock, never on the prescaled tick
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cap_samp_r <= 1'b0;
            nf_sh_r <= '0;
            nf_out_r <= 1'b0;
            edge_prev_r <= 1'b0;
        end else begin
            cap_samp_r <= cap_src;
            nf_sh_r <= nf_win[`TC16_NF_LEN-2:0];
            nf_out_r <= nf_nxt;
            if (!cap_top) edge_prev_r <= det_in;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            capture_irq_r <= 1'b0;
            overflow_irq_r <= 1'b0;
        end else begin
            pready_r <= acc_first;
            pslverr_r <= acc_first && !mapped;
            if (rd_take) prdata_r <= {24'h00_0000, rd_byte};
            capture_irq_r <= cap_evt || (capture_flag_r && !cap_clr)
                ? irq_mask_reg_r[`TC16_F_CAP] : 1'b0;
            overflow_irq_r <= (ovf_evt || (overflow_flag_r && !ovf_clr))
                && irq_mask_reg_r[`TC16_F_OVF];
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign capture_irq = capture_irq_r;
    assign overflow_irq = overflow_irq_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_first;
        psel && penable && !pready_r;
    endsequence
    sequence s_done;
        pready_r ##1 !pready_r;
    endsequence

    bus_wait_state_a: assert property (s_first |=> s_done)
        else $error("ready not one cycle after access start");
    stop_holds_a: assert property (cs == TC16_CS_STOP && !cnt_wr |=> $stable(timer_count_r))
        else $error("counter moved while stopped");
    lo_read_temp_a: assert property (rd_take && a_clo |=> temp_r == $past(timer_count_r[15:8]))
        else $error("latch missed counter upper byte");
    wr_wins_a: assert property (cnt_wr |=> timer_count_r == {$past(temp_r), $past(wb)})
        else $error("counter write lost");
    cap_copy_a: assert property (cap_evt |=> capture_flag_r
        && capture_value_r == $past(timer_count_r))
        else $error("capture did not copy counter");
    cap_gate_a: assert property (wr_do && a_plo && !cap_top && !cap_evt
        |=> $stable(capture_value_r))
        else $error("capture written outside top mode");
    nf_agree_a: assert property (nf_out_r != $past(nf_out_r) |-> $past(nf_agree))
        else $error("filter changed without four equal samples");
    ovf_wrap_a: assert property (tick && waveform_mode == 4'd0 && !cnt_wr
        && timer_count_r == `TC16_MAX |=> overflow_flag_r && timer_count_r == 16'h0000)
        else $error("normal mode overflow missing");
    hi_read_temp_a: assert property (rd_take && (a_chi || a_phi)
        |=> prdata_r[7:0] == $past(temp_r))
        else $error("upper read not from latch");
    cap_irq_a: assert property (capture_flag_r && irq_mask_reg_r[`TC16_F_CAP]
        && !cap_clr |=> capture_irq_r)
        else $error("capture interrupt missing");

    // Single counting steps when no write competes, and upper-write and capture-lower-read patterns
    sequence s_step_up;
        tick && !updown && !at_top && !cnt_wr;
    endsequence
    sequence s_step_down;
        tick && updown && dir_down_r && !at_bot && !cnt_wr;
    endsequence
    sequence s_hi_write;
        wr_do && (a_chi || a_phi);
    endsequence
    sequence s_cap_lo_read;
        rd_take && a_plo;
    endsequence

    up_step_a: assert property (s_step_up
        |=> timer_count_r == $past(timer_count_r) + 16'h0001)
        else $error("counter did not increment");
    down_step_a: assert property (s_step_down
        |=> timer_count_r == $past(timer_count_r) - 16'h0001)
        else $error("counter did not decrement");
    ovf_set_a: assert property (ovf_evt |=> overflow_flag_r)
        else $error("overflow flag not set");
    ovf_irq_a: assert property (overflow_flag_r && irq_mask_reg_r[`TC16_F_OVF]
        && !ovf_clr |=> overflow_irq_r)
        else $error("overflow interrupt missing");
    cap_clear_a: assert property (capture_flag_r && cap_clr && !cap_evt
        |=> !capture_flag_r)
        else $error("capture flag not cleared");
    cap_lo_temp_a: assert property (s_cap_lo_read
        |=> temp_r == $past(capture_value_r[15:8]))
        else $error("latch missed capture upper byte");
    hi_write_temp_a: assert property (s_hi_write |=> temp_r == $past(wb))
        else $error("upper write missed latch");
    hi_no_count_a: assert property (wr_do && (a_chi || a_phi) && !tick
        |=> $stable(timer_count_r))
        else $error("upper write reached counter");
    temp_hold_a: assert property (!rd_take && !wr_do |=> $stable(temp_r))
        else $error("latch changed without access");
    cap_top_wr_a: assert property (cap_wr && !cap_evt
        |=> capture_value_r == {$past(temp_r), $past(wb)})
        else $error("capture top write lost");
    top_no_cap_a: assert property (cap_top && !cap_wr |=> $stable(capture_value_r))
        else $error("capture moved in capture-top mode");
    pin_sample_a: assert property (!src_cmp |=> cap_samp_r == $past(capture_pin))
        else $error("pin not sampled");
    comp_sample_a: assert property (src_cmp
        |=> cap_samp_r == $past(comparator_output))
        else $error("comparator not sampled");
    ext_idle_a: assert property (cs == TC16_CS_EXT_RISE
        && ext_prev_r == ext_clock_pin |-> !tick)
        else $error("tick without external edge");
    bypass_cap_a: assert property (!nf_en && !cap_top && rise_sel && cap_samp_r
        && !edge_prev_r |=> capture_flag_r)
        else $error("unfiltered edge not captured");
    unmapped_err_a: assert property (acc_first && !mapped |=> pslverr_r)
        else $error("unmapped access without error");
endmodule

/* File: tc16_cfg.svh */
`ifndef TC16_CFG_SVH
`define TC16_CFG_SVH
// Register byte addresses
`define TC16_ADR_CTRL_A 8'h00
`define TC16_ADR_CTRL_B 8'h04
`define TC16_ADR_CNT_LO 8'h08
`define TC16_ADR_CNT_HI 8'h0C
`define TC16_ADR_CAP_LO 8'h10
`define TC16_ADR_CAP_HI 8'h14
`define TC16_ADR_MASK 8'h18
`define TC16_ADR_FLAG 8'h1C
`define TC16_ADR_COMP 8'h20
// Field positions
`define TC16_B_EDGE 6
`define TC16_B_NF 7
`define TC16_F_OVF 0
`define TC16_F_CAP 5
`define TC16_B_COMPARATOR_CAPTURE_SELECT 2
// Reset values
`define TC16_RST_BYTE 8'h00
`define TC16_RST_WORD 16'h0000
// Fixed tops and filter length
`define TC16_TOP8 16'h00FF
`define TC16_TOP9 16'h01FF
`define TC16_TOP10 16'h03FF
`define TC16_MAX 16'hFFFF
`define TC16_NF_LEN 4
`endif

/* File: tc16_pkg.sv */
package tc16_pkg;
    typedef logic [15:0] tc16_word_t;
    typedef enum logic [2:0] {
        TC16_CS_STOP = 3'b000,
        TC16_CS_DIV1 = 3'b001,
        TC16_CS_DIV8 = 3'b010,
        TC16_CS_DIV64 = 3'b011,
        TC16_CS_DIV256 = 3'b100,
        TC16_CS_DIV1024 = 3'b101,
        TC16_CS_EXT_FALL = 3'b110,
        TC16_CS_EXT_RISE = 3'b111
    } tc16_cs_e;
endpackage

/* File: tc16_cpu_model.sv */
`timescale 1ns/1ns
module tc16_cpu_model (
    input wire logic clk, // Bus clock
    output logic psel, // APB select
    output logic penable, // APB enable
    output logic pwrite, // APB direction
    output logic [7:0] paddr, // APB byte address
    output logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr // APB error
);
    logic last_err;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        last_err = 1'b0;
    end

    // Request held until pready is sampled high; no fixed latency assumed
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        q = prdata[7:0];
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Both halves issued back to back, nothing else may touch the shared latch
    task automatic wr16(input logic [7:0] hi, input logic [7:0] lo, input logic [15:0] v);
        logic [7:0] t;
        xfer(1'b1, hi, v[15:8], t);
        xfer(1'b1, lo, v[7:0], t);
    endtask

    task automatic rd16(input logic [7:0] lo, input logic [7:0] hi, output logic [15:0] v);
        logic [7:0] a;
        logic [7:0] b;
        xfer(1'b0, lo, 8'h00, a);
        xfer(1'b0, hi, 8'h00, b);
        v = {b, a};
    endtask
endmodule

/* File: sixteen_bit_timer_capture_tb_top.sv */
`timescale 1ns/1ns
`include "tc16_cfg.svh"
module sixteen_bit_timer_capture_tb_top;
    import tc16_pkg::*;
    logic clk, reset, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic capture_pin, comparator_output, ext_clock_pin;
    logic capture_irq_ack, overflow_irq_ack, capture_irq, overflow_irq;
    logic [7:0] q;
    logic [15:0] w;
    int errors, total_checks, d0, d1;

    tc16_timer dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
        .comparator_output(comparator_output), .ext_clock_pin(ext_clock_pin),
        .capture_irq_ack(capture_irq_ack), .overflow_irq_ack(overflow_irq_ack),
        .capture_irq(capture_irq), .overflow_irq(overflow_irq));
    tc16_cpu_model cpu (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    always #50 clk = ~clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("Mismatches %0d of %0d checks", errors, total_checks);
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cpu.xfer(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        cpu.xfer(1'b0, a, 8'h00, q);
        chk({24'h000000, q}, {24'h000000, exp});
    endtask

    task automatic rd16_chk(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] exp);
        cpu.rd16(lo, hi, w);
        chk({16'h0000, w}, {16'h0000, exp});
    endtask

    task automatic set_cnt(input logic [15:0] v);
        cpu.wr16(`TC16_ADR_CNT_HI, `TC16_ADR_CNT_LO, v);
    endtask

    // Toggle the pin and count edges until the registered request shows
    task automatic cap_delay(output int n);
        n = 0;
        @(posedge clk);
        capture_pin <= ~capture_pin;
        do begin
            @(posedge clk);
            n++;
        end while (capture_irq !== 1'b1 && n < 40);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        close_out();
    end

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        capture_pin = 1'b0;
        comparator_output = 1'b0;
        ext_clock_pin = 1'b0;
        capture_irq_ack = 1'b0;
        overflow_irq_ack = 1'b0;
        errors = 0;
        total_checks = 0;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        rd_chk(`TC16_ADR_CTRL_B, `TC16_RST_BYTE);
        rd_chk(`TC16_ADR_FLAG, `TC16_RST_BYTE);
        wr(8'h24, 8'hA5);
        cpu.xfer(1'b0, 8'h24, 8'h00, q);
        chk({31'h0, cpu.last_err}, 32'h1);
        chk({24'h0, q}, 32'h0);
        set_cnt(16'h1234);
        rd16_chk(`TC16_ADR_CNT_LO, `TC16_ADR_CNT_HI, 16'h1234);
        wr(`TC16_ADR_CNT_HI, 8'h77);
        rd_chk(`TC16_ADR_CNT_HI, 8'h77);
        rd16_chk(`TC16_ADR_CNT_LO, `TC16_ADR_CNT_HI, 16'h1234);
        wr(`TC16_ADR_CTRL_B, {5'h00, TC16_CS_EXT_RISE});
        repeat (5) begin
            cyc(3);
            ext_clock_pin <= 1'b1;
            cyc(3);
            ext_clock_pin <= 1'b0;
        end
        cyc(6);
        wr(`TC16_ADR_CTRL_B, 8'h00);
        rd16_chk(`TC16_ADR_CNT_LO, `TC16_ADR_CNT_HI, 16'h1239);
        wr(`TC16_ADR_MASK, 8'h01);
        set_cnt(16'hFFF8);
        wr(`TC16_ADR_CTRL_B, {5'h00, TC16_CS_DIV1});
        cyc(20);
        chk({31'h0, overflow_irq}, 32'h1);
        // Write lands while the counter ticks every cycle
        set_cnt(16'h4000);
        wr(`TC16_ADR_CTRL_B, 8'h00);
        cpu.rd16(`TC16_ADR_CNT_LO, `TC16_ADR_CNT_HI, w);
        chk({31'h0, w >= 16'h4000 && w < 16'h4010}, 32'h1);
        @(posedge clk);
        overflow_irq_ack <= 1'b1;
        @(posedge clk);
        overflow_irq_ack <= 1'b0;
        cyc(2);
        chk({31'h0, overflow_irq}, 32'h0);
        rd_chk(`TC16_ADR_FLAG, 8'h00);
        wr(`TC16_ADR_CTRL_A, 8'h01);
        set_cnt(16'h00F0);
        wr(`TC16_ADR_CTRL_B, {5'h00, TC16_CS_DIV1});
        cyc(40);
        wr(`TC16_ADR_CTRL_B, 8'h00);
        cpu.rd16(`TC16_ADR_CNT_LO, `TC16_ADR_CNT_HI, w);
        chk({31'h0, w <= `TC16_TOP8 && w >= 16'h00C0}, 32'h1);
        wr(`TC16_ADR_CTRL_A, 8'h00);
        wr(`TC16_ADR_CTRL_B, 8'h58);
        cpu.wr16(`TC16_ADR_CAP_HI, `TC16_ADR_CAP_LO, 16'h0010);
        rd16_chk(`TC16_ADR_CAP_LO, `TC16_ADR_CAP_HI, 16'h0010);
        set_cnt(16'h0000);
        wr(`TC16_ADR_CTRL_B, 8'h59);
        capture_pin <= 1'b1;
        cyc(30);
        capture_pin <= 1'b0;
        wr(`TC16_ADR_CTRL_B, 8'h58);
        cpu.rd16(`TC16_ADR_CNT_LO, `TC16_ADR_CNT_HI, w);
        chk({31'h0, w <= 16'h0010}, 32'h1);
        rd_chk(`TC16_ADR_FLAG, 8'h00);
        wr(`TC16_ADR_CTRL_B, 8'h40);
        cpu.wr16(`TC16_ADR_CAP_HI, `TC16_ADR_CAP_LO, 16'hABCD);
        rd16_chk(`TC16_ADR_CAP_LO, `TC16_ADR_CAP_HI, 16'h0010);
        set_cnt(16'h2345);
        wr(`TC16_ADR_MASK, 8'h20);
        wr(`TC16_ADR_FLAG, 8'h21);
        cap_delay(d0);
        rd_chk(`TC16_ADR_FLAG, 8'h20);
        rd16_chk(`TC16_ADR_CAP_LO, `TC16_ADR_CAP_HI, 16'h2345);
        @(posedge clk);
        capture_irq_ack <= 1'b1;
        @(posedge clk);
        capture_irq_ack <= 1'b0;
        cyc(2);
        chk({31'h0, capture_irq}, 32'h0);
        rd_chk(`TC16_ADR_FLAG, 8'h00);
        capture_pin <= 1'b0;
        cyc(10);
        rd_chk(`TC16_ADR_FLAG, 8'h00);
        set_cnt(16'h2222);
        capture_pin <= 1'b1;
        cyc(10);
        set_cnt(16'h3333);
        wr(`TC16_ADR_CTRL_B, 8'h00);
        wr(`TC16_ADR_FLAG, 8'h21);
        capture_pin <= 1'b0;
        cyc(10);
        rd16_chk(`TC16_ADR_CAP_LO, `TC16_ADR_CAP_HI, 16'h3333);
        wr(`TC16_ADR_CTRL_B, 8'hC0);
        wr(`TC16_ADR_FLAG, 8'h21);
        // Three equal samples must not move the filter
        capture_pin <= 1'b1;
        cyc(3);
        capture_pin <= 1'b0;
        cyc(12);
        rd_chk(`TC16_ADR_FLAG, 8'h00);
        cap_delay(d1);
        chk(32'(d1 - d0), 32'd4);
        wr(`TC16_ADR_CTRL_B, 8'h40);
        wr(`TC16_ADR_COMP, 8'h04);
        capture_pin <= 1'b0;
        cyc(10);
        wr(`TC16_ADR_FLAG, 8'h21);
        set_cnt(16'h0ACE);
        comparator_output <= 1'b1;
        cyc(10);
        rd_chk(`TC16_ADR_FLAG, 8'h20);
        rd16_chk(`TC16_ADR_CAP_LO, `TC16_ADR_CAP_HI, 16'h0ACE);
        wr(`TC16_ADR_FLAG, 8'h21);
        capture_pin <= 1'b1;
        cyc(10);
        rd_chk(`TC16_ADR_FLAG, 8'h00);
        close_out();
    end
endmodule
